// ### hdl/fmirq_core.sv
// Fault monitor, flag registers, mode control and interrupt output
`timescale 1ns/1ps
`default_nettype none
module fmirq_core #(
	parameter int P_UV_CYC = fmirq_pkg::cyc(fmirq_pkg::T_UV_NS),
	parameter int P_OV_CYC = fmirq_pkg::cyc(fmirq_pkg::T_OV_NS),
	parameter int P_SC_CYC = fmirq_pkg::cyc(fmirq_pkg::T_SC_NS),
	parameter int P_BATT_CYC = fmirq_pkg::cyc(fmirq_pkg::T_BATT_NS),
	parameter int P_INITWD_CYC = fmirq_pkg::cyc(fmirq_pkg::T_INITWD_NS),
	parameter int P_WDUNIT_CYC = fmirq_pkg::cyc(fmirq_pkg::T_WDUNIT_NS)
) (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic sclk,
	input wire logic spi_cs_n,
	input wire logic spi_sdi,
	output logic spi_sdo,
	input wire logic lin_bus_rx,
	input wire logic thermal_shutdown,
	input wire logic core_supply_low,
	input wire logic core_supply_high,
	input wire logic core_supply_short,
	input wire logic battery_supply_low,
	output logic irq_out_n,
	output logic reset_out_n,
	output logic transceiver_on,
	output logic wake_enable,
	output fmirq_pkg::fmirq_mode_e mode
);
	import fmirq_pkg::*;
	// ****************************************
	// Pin synchronisation and link
	// ****************************************
	logic [6:0] pin_s;
	logic rx_s, cs_s, cs_q, f_vld;
	fmirq_frame_s frm_l, frm_c;
	logic [7:0] rd_byte;
	fmirq_sync #(.W(7)) u_sync (
		.clk(mclk),
		.rst(sys_rst),
		.d({~spi_cs_n, ~lin_bus_rx, battery_supply_low, core_supply_short,
			core_supply_high, core_supply_low, thermal_shutdown}),
		.q(pin_s)
	);
	// Select and bus pass inverted so the reset value is their idle level;
	// otherwise a false frame edge would follow every reset
	assign rx_s = !pin_s[5];
	assign cs_s = !pin_s[6];
	fmirq_spi_link u_link (
		.sclk(sclk),
		.cs_n(spi_cs_n),
		.sdi(spi_sdi),
		.rd_byte(rd_byte),
		.sdo(spi_sdo),
		.frm(frm_l)
	);
	// Frame is taken only once the synced select is high, the clock idle
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			cs_q <= 1'b1;
			f_vld <= 1'b0;
			frm_c <= '0;
		end else begin
			cs_q <= cs_s;
			f_vld <= cs_s & ~cs_q;
			if (cs_s & ~cs_q) begin
				frm_c <= frm_l;
			end
		end
	end
	// ****************************************
	// Frame checks and write decode
	// ****************************************
	logic crc_ok, cnt_ok, wr_ok, bad_frm;
	logic [6:0] w_addr;
	logic [7:0] w_data;
	assign crc_ok = crc8(frm_c.bits[23:8]) == frm_c.bits[7:0];
	assign cnt_ok = frm_c.cnt == 6'(FRAME_BITS);
	assign w_addr = frm_c.bits[22:16];
	assign w_data = frm_c.bits[15:8];
	assign wr_ok = f_vld & frm_c.bits[23] & crc_ok & cnt_ok;
	assign bad_frm = f_vld & ~(crc_ok & cnt_ok);
	function automatic logic [7:0] clr(input logic [6:0] a);
		return (wr_ok && w_addr == a) ? w_data : 8'h00;
	endfunction
	// ****************************************
	// Fault filters
	// ****************************************
	logic [NFLT-1:0][25:0] lim;
	logic [NFLT-1:0] flt_on, flt_q, rise;
	assign lim = {26'(P_BATT_CYC), 26'(P_SC_CYC), 26'(P_OV_CYC),
		26'(P_UV_CYC), 26'(TSD_CYC)};
	genvar g;
	for (g = 0; g < NFLT; g++) begin : g_flt
		logic [25:0] cnt;
		logic hit;
		// All monitors rest in sleep
		always_ff @(posedge mclk) begin
			if (sys_rst || !pin_s[g] || mode == M_SLEEP) begin
				cnt <= '0;
				hit <= 1'b0;
			end else if (cnt + 26'h1 >= lim[g]) begin
				hit <= 1'b1;
			end else begin
				cnt <= cnt + 26'h1;
			end
		end
		assign flt_on[g] = hit;
	end
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			flt_q <= '0;
		end else begin
			flt_q <= flt_on;
		end
	end
	assign rise = flt_on & ~flt_q;
	// ****************************************
	// Control registers
	// ****************************************
	logic [7:0] act, wd_lo, wd_lim;
	logic [4:0] wd_hi;
	logic kick, host_req;
	assign kick = wr_ok && w_addr == A_KICK;
	assign host_req = wr_ok && w_addr == A_MODE;
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			act <= ACT_RST;
			wd_lo <= WDLO_RST;
			wd_hi <= WDHI_RST;
			wd_lim <= WDLIM_RST;
		end else if (wr_ok) begin
			if (w_addr == A_ACT) act <= w_data;
			if (w_addr == A_WDLO) wd_lo <= w_data;
			if (w_addr == A_WDHI) wd_hi <= w_data[4:0];
			if (w_addr == A_WDLIM) wd_lim <= w_data;
		end
	end
	// ****************************************
	// Watchdog
	// ****************************************
	logic [25:0] ucnt, iw_cnt;
	logic tick, iw_arm, iw_miss, wd_err, wd_trip, timeout;
	logic [13:0] wd_cnt, wd_per;
	logic [7:0] err_cnt;
	fmirq_mode_e mode_q;
	// Period in 4 ms units, 1 to 8192 units
	assign wd_per = {1'b0, wd_hi, wd_lo} + 14'h1;
	assign tick = ucnt == 26'(P_WDUNIT_CYC - 1);
	always_ff @(posedge mclk) begin
		if (sys_rst || tick) begin
			ucnt <= '0;
		end else begin
			ucnt <= ucnt + 26'h1;
		end
	end
	assign timeout = wd_cnt == wd_per;
	// Early service, before half the period, counts as an error
	assign wd_err = mode == M_NORMAL &&
		((kick && wd_cnt < (wd_per >> 1)) || timeout);
	assign wd_trip = wd_err && err_cnt >= wd_lim;
	always_ff @(posedge mclk) begin
		if (sys_rst || mode != M_NORMAL || kick || timeout) begin
			wd_cnt <= '0;
		end else if (tick) begin
			wd_cnt <= wd_cnt + 14'h1;
		end
	end
	always_ff @(posedge mclk) begin
		if (sys_rst || wd_trip) begin
			err_cnt <= '0;
		end else if (wd_err) begin
			err_cnt <= err_cnt + 8'h01;
		end
	end
	assign iw_miss = mode == M_STANDBY && mode_q == M_STANDBY && iw_arm &&
		!kick && iw_cnt == 26'(P_INITWD_CYC - 1);
	always_ff @(posedge mclk) begin
		if (sys_rst || mode != M_STANDBY) begin
			iw_arm <= 1'b0;
			iw_cnt <= '0;
		end else if (mode_q != M_STANDBY) begin
			iw_arm <= 1'b1;
			iw_cnt <= '0;
		end else if (kick || iw_miss) begin
			iw_arm <= 1'b0;
		end else if (iw_arm) begin
			iw_cnt <= iw_cnt + 26'h1;
		end
	end
	// ****************************************
	// Stuck dominant lockout
	// ****************************************
	logic sampled, lockout, wake;
	logic [9:0] bcnt;
	logic bdone;
	assign bdone = bcnt == 10'(BUS_CYC - 1);
	// Comparing with lockout picks recessive to unlock, dominant to wake
	always_ff @(posedge mclk) begin
		if (sys_rst || mode != M_SLEEP) begin
			sampled <= 1'b0;
			lockout <= 1'b0;
			bcnt <= '0;
		end else if (!sampled) begin
			bcnt <= bdone ? 10'h000 : bcnt + 10'h001;
			if (bdone) begin
				sampled <= 1'b1;
				lockout <= !rx_s;
			end
		end else if (rx_s == lockout) begin
			bcnt <= bdone ? 10'h000 : bcnt + 10'h001;
			if (bdone) lockout <= 1'b0;
		end else begin
			bcnt <= '0;
		end
	end
	assign wake = mode == M_SLEEP && sampled && !lockout && !rx_s && bdone;
	// ****************************************
	// Flag registers, set wins over clear
	// ****************************************
	logic [7:0] fl_therm, fl_wd, fl_sup, fl_lnk;
	logic [7:0] s_therm, s_wd, s_sup, s_lnk;
	always_comb begin
		s_therm = '0;
		s_wd = '0;
		s_sup = '0;
		s_lnk = '0;
		s_therm[B_TH_A] = rise[F_TSD];
		s_therm[B_TH_B] = rise[F_TSD];
		s_sup[B_SUP_TSD] = rise[F_TSD];
		s_sup[B_SUP_UV] = rise[F_UV];
		s_sup[B_SUP_OV] = rise[F_OV];
		s_sup[B_SUP_BATT] = rise[F_BATT];
		s_lnk[B_LNK_SC] = rise[F_SC];
		s_wd[B_WD] = iw_miss | wd_trip;
		s_lnk[B_LNK_CRC] = f_vld & cnt_ok & !crc_ok;
		s_lnk[B_LNK_FRM] = f_vld & !cnt_ok;
	end
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			fl_therm <= '0;
			fl_wd <= '0;
			fl_sup <= '0;
			fl_lnk <= '0;
		end else begin
			fl_therm <= (fl_therm & ~clr(A_THERM)) | s_therm;
			fl_wd <= (fl_wd & ~clr(A_WDF)) | s_wd;
			fl_sup <= (fl_sup & ~clr(A_SUP)) | s_sup;
			fl_lnk <= (fl_lnk & ~clr(A_LNK)) | s_lnk;
		end
	end
	// ****************************************
	// Mode control
	// ****************************************
	fmirq_mode_e next_mode, req_mode;
	always_comb begin
		case (w_data[1:0])
			REQ_NORMAL: req_mode = M_NORMAL;
			REQ_SLEEP: req_mode = M_SLEEP;
			default: req_mode = M_STANDBY;
		endcase
	end
	// Later checks win: thermal over short over overvoltage
	always_comb begin
		next_mode = mode;
		case (mode)
			M_NORMAL, M_STANDBY: begin
				if (host_req) next_mode = req_mode;
			end
			M_SLEEP: begin
				if (wake) next_mode = M_STANDBY;
			end
			M_FAILSAFE: begin
				if (host_req && !(|flt_on)) next_mode = req_mode;
			end
			M_RESTART: begin
				if (!flt_on[F_UV]) next_mode = M_STANDBY;
			end
			M_THERMAL: begin
				if (!flt_on[F_TSD]) next_mode = M_STANDBY;
			end
			default: next_mode = M_STANDBY;
		endcase
		if (wd_trip) begin
			next_mode = act[ACT_WD] ? M_FAILSAFE : M_RESTART;
		end
		if (rise[F_UV]) begin
			next_mode = act[ACT_UV] ? M_FAILSAFE : M_RESTART;
		end
		if (rise[F_OV]) begin
			next_mode = act[ACT_OV] ? M_SLEEP : M_FAILSAFE;
		end
		if (rise[F_SC]) begin
			next_mode = act[ACT_SC] ? M_SLEEP : M_FAILSAFE;
		end
		if (rise[F_TSD]) begin
			next_mode = act[ACT_TSD] ? M_THERMAL : M_FAILSAFE;
		end
	end
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			mode <= M_STANDBY;
			mode_q <= M_RESTART;
		end else begin
			mode <= next_mode;
			mode_q <= mode;
		end
	end
	// ****************************************
	// Outputs and read data
	// ****************************************
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			irq_out_n <= 1'b1;
			reset_out_n <= 1'b0;
			transceiver_on <= 1'b0;
			wake_enable <= 1'b1;
		end else begin
			irq_out_n <= !(|{fl_therm, fl_wd, fl_sup, fl_lnk});
			reset_out_n <= !(flt_on[F_UV] || wd_trip ||
				mode == M_RESTART);
			// Thermal and fail-safe states keep the driver off
			transceiver_on <= mode == M_NORMAL;
			wake_enable <= !lockout;
		end
	end
	// Read byte changes only between frames, while the link clock idles
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			rd_byte <= '0;
		end else if (f_vld) begin
			case (w_addr)
				A_THERM: rd_byte <= fl_therm;
				A_WDF: rd_byte <= fl_wd;
				A_SUP: rd_byte <= fl_sup;
				A_LNK: rd_byte <= fl_lnk;
				A_ACT: rd_byte <= act;
				A_WDLO: rd_byte <= wd_lo;
				A_WDHI: rd_byte <= {3'h0, wd_hi};
				A_WDLIM: rd_byte <= wd_lim;
				A_STAT: rd_byte <= {1'b0, lockout, mode};
				A_WDERR: rd_byte <= err_cnt;
				default: rd_byte <= 8'h00;
			endcase
		end
	end
	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);
	sequence s_tsd_flags;
		fl_therm[B_TH_A] && fl_therm[B_TH_B] && fl_sup[B_SUP_TSD];
	endsequence
	property p_lock;
		$rose(sampled) |-> lockout == !$past(rx_s);
	endproperty
	a_lock: assert property (p_lock) else $error("lockout sample wrong");
	property p_unlock;
		$fell(lockout) && mode == M_SLEEP |-> $past(rx_s, 1) && $past(rx_s, 2);
	endproperty
	a_unlock: assert property (p_unlock) else $error("unlock w/o recessive");
	property p_tsd;
		rise[F_TSD] |=> s_tsd_flags ##1 !transceiver_on && !irq_out_n;
	endproperty
	a_tsd: assert property (p_tsd) else $error("thermal reaction wrong");
	property p_tsd_mode;
		rise[F_TSD] |=> mode inside {M_FAILSAFE, M_THERMAL};
	endproperty
	a_tsd_mode: assert property (p_tsd_mode) else $error("thermal mode");
	property p_uv;
		rise[F_UV] |=> fl_sup[B_SUP_UV] && !reset_out_n ##1 !irq_out_n;
	endproperty
	a_uv: assert property (p_uv) else $error("undervoltage reaction");
	property p_ov_sc;
		rise[F_OV] || rise[F_SC] |=>
			(fl_sup[B_SUP_OV] || fl_lnk[B_LNK_SC]) && mode != M_NORMAL;
	endproperty
	a_ov_sc: assert property (p_ov_sc) else $error("supply fault");
	property p_iw;
		iw_miss |=> fl_wd[B_WD] ##1 !irq_out_n;
	endproperty
	a_iw: assert property (p_iw) else $error("standby window miss");
	property p_trip;
		wd_trip |=> fl_wd[B_WD] && err_cnt == 8'h00 &&
			mode inside {M_FAILSAFE, M_RESTART};
	endproperty
	a_trip: assert property (p_trip) else $error("watchdog trip");
	property p_block;
		bad_frm |=> $stable(act) && $stable(wd_lim) && $stable(wd_lo);
	endproperty
	a_block: assert property (p_block) else $error("bad frame wrote");
	property p_frm;
		f_vld && !cnt_ok |=> fl_lnk[B_LNK_FRM] ##1 !irq_out_n;
	endproperty
	a_frm: assert property (p_frm) else $error("count error missed");
	property p_irq;
		|{fl_therm, fl_wd, fl_sup, fl_lnk} |=> !irq_out_n;
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt released");
endmodule // fmirq_core
`default_nettype wire

// ### hdl/fmirq_pkg.sv
// Constants and types shared by the fault monitor interrupt logic
`default_nettype none
package fmirq_pkg;
	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_NS = 4;
	localparam int T_BUS_NS = 3000;
	localparam int T_TSD_NS = 10000;
	localparam int T_UV_NS = 4000000;
	localparam int T_OV_NS = 150000;
	localparam int T_SC_NS = 125000;
	localparam int T_BATT_NS = 125000;
	localparam int T_INITWD_NS = 200000000;
	localparam int T_WDUNIT_NS = 4000000;
	// Least times round up to whole cycles
	function automatic int cyc(input int t_ns);
		return (t_ns + CLK_NS - 1) / CLK_NS;
	endfunction
	localparam int BUS_CYC = cyc(T_BUS_NS);
	localparam int TSD_CYC = cyc(T_TSD_NS);
	// ****************************************
	// Register map
	// ****************************************
	localparam logic [6:0] A_MODE = 7'h10;
	localparam logic [6:0] A_ACT = 7'h11;
	localparam logic [6:0] A_WDLO = 7'h12;
	localparam logic [6:0] A_WDHI = 7'h13;
	localparam logic [6:0] A_WDLIM = 7'h14;
	localparam logic [6:0] A_KICK = 7'h15;
	localparam logic [6:0] A_STAT = 7'h16;
	localparam logic [6:0] A_WDERR = 7'h17;
	localparam logic [6:0] A_THERM = 7'h50;
	localparam logic [6:0] A_WDF = 7'h51;
	localparam logic [6:0] A_SUP = 7'h52;
	localparam logic [6:0] A_LNK = 7'h53;
	localparam int B_TH_A = 7;
	localparam int B_TH_B = 5;
	localparam int B_SUP_TSD = 1;
	localparam int B_SUP_UV = 2;
	localparam int B_SUP_BATT = 4;
	localparam int B_SUP_OV = 5;
	localparam int B_WD = 7;
	localparam int B_LNK_SC = 3;
	localparam int B_LNK_CRC = 4;
	localparam int B_LNK_FRM = 7;
	localparam int ACT_UV = 0;
	localparam int ACT_OV = 1;
	localparam int ACT_SC = 2;
	localparam int ACT_WD = 3;
	localparam int ACT_TSD = 4;
	localparam logic [7:0] ACT_RST = 8'h00;
	localparam logic [7:0] WDLO_RST = 8'hF9;
	localparam logic [4:0] WDHI_RST = 5'h00;
	localparam logic [7:0] WDLIM_RST = 8'h03;
	localparam logic [1:0] REQ_NORMAL = 2'h0;
	localparam logic [1:0] REQ_STANDBY = 2'h1;
	localparam logic [1:0] REQ_SLEEP = 2'h2;
	// ****************************************
	// Serial frame and faults
	// ****************************************
	localparam int FRAME_BITS = 24;
	localparam logic [7:0] CRC_POLY = 8'h07;
	localparam logic [7:0] CRC_INIT = 8'hFF;
	localparam int F_TSD = 0;
	localparam int F_UV = 1;
	localparam int F_OV = 2;
	localparam int F_SC = 3;
	localparam int F_BATT = 4;
	localparam int NFLT = 5;
	typedef enum logic [5:0] {
		M_NORMAL = 6'h01,
		M_STANDBY = 6'h02,
		M_SLEEP = 6'h04,
		M_FAILSAFE = 6'h08,
		M_RESTART = 6'h10,
		M_THERMAL = 6'h20
	} fmirq_mode_e;
	typedef struct packed {
		logic [FRAME_BITS-1:0] bits;
		logic [5:0] cnt;
	} fmirq_frame_s;
	function automatic logic [7:0] crc8(input logic [15:0] d);
		logic [7:0] c;
		c = CRC_INIT;
		for (int i = 15; i >= 0; i--) begin
			c = (c[7] ^ d[i]) ? ((c << 1) ^ CRC_POLY) : (c << 1);
		end
		return c;
	endfunction
endpackage
`default_nettype wire

// ### hdl/fmirq_sync.sv
// Two-flop synchroniser for asynchronous pin levels
`timescale 1ns/1ps
`default_nettype none
module fmirq_sync #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta;
	always_ff @(posedge clk) begin
		if (rst) begin
			meta <= '0;
			q <= '0;
		end else begin
			meta <= d;
			q <= meta;
		end
	end
endmodule // fmirq_sync
`default_nettype wire

// ### hdl/fmirq_spi_link.sv
// Serial link front end on the host's serial clock
`timescale 1ns/1ps
`default_nettype none
module fmirq_spi_link (
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic sdi,
	input wire logic [7:0] rd_byte,
	output logic sdo,
	output fmirq_pkg::fmirq_frame_s frm
);
	import fmirq_pkg::*;
	// ****************************************
	// Shift and clock count
	// ****************************************
	// Clock stops between frames, so chip select clears the start flag and the first edge reloads the count
	logic started;
	always_ff @(posedge sclk or posedge cs_n) begin
		if (cs_n) begin
			started <= 1'b0;
		end else begin
			started <= 1'b1;
		end
	end
	// Frame stays put after the last edge for the core to take
	always_ff @(posedge sclk) begin
		frm.bits <= {frm.bits[FRAME_BITS-2:0], sdi};
		if (!started) begin
			frm.cnt <= 6'h01;
		end else if (frm.cnt != 6'h3F) begin
			frm.cnt <= frm.cnt + 6'h01;
		end
	end
	always_ff @(posedge sclk or posedge cs_n) begin
		if (cs_n) begin
			sdo <= 1'b0;
		end else if (!started) begin
			sdo <= rd_byte[7];
		end else if (frm.cnt < 6'h08) begin
			sdo <= rd_byte[3'h7 - frm.cnt[2:0]];
		end else begin
			sdo <= 1'b0;
		end
	end
endmodule // fmirq_spi_link
`default_nettype wire

// ### tb/fmirq_host.sv
// Host side model: serial frame master for the fault monitor
`timescale 1ns/1ps
`default_nettype none
module fmirq_host (
	output logic sclk,
	output logic cs_n,
	output logic sdi,
	input wire logic sdo
);
	// ****************************************
	// Idle levels follow the pin pull-ups
	// ****************************************
	initial begin
		sclk = 1'b1;
		cs_n = 1'b1;
		sdi = 1'b1;
	end
	function automatic logic [7:0] crc(input logic [15:0] d);
		logic [7:0] c;
		c = 8'hFF;
		for (int i = 15; i >= 0; i--) begin
			c = (c[7] ^ d[i]) ? ((c << 1) ^ 8'h07) : (c << 1);
		end
		return c;
	endfunction
	// ****************************************
	// One frame; clock count and checksum fault only on request
	// ****************************************
	task automatic xfer(input logic [15:0] hd, input int nclk,
		input logic bad, output logic [7:0] rd);
		logic [23:0] f;
		f = {hd, crc(hd) ^ (bad ? 8'h01 : 8'h00)};
		rd = 8'h00;
		#7 cs_n = 1'b0;
		for (int i = 0; i < nclk; i++) begin
			sclk = 1'b0;
			sdi = f[23 - (i % 24)];
			#16 sclk = 1'b1;
			#8;
			if (i < 8) begin
				rd[7 - i] = sdo;
			end
			#8;
		end
		#16 cs_n = 1'b1;
		sdi = 1'b1;
		#100;
	endtask
endmodule // fmirq_host
`default_nettype wire

// ### tb/fmirq_core_tb.sv
// Self-checking testbench for the fault monitor interrupt logic
`timescale 1ns/1ps
`default_nettype none
module fmirq_core_tb;
	import fmirq_pkg::*;
	logic mclk = 1'b0;
	logic sys_rst = 1'b1;
	logic lin_bus_rx = 1'b1;
	logic [4:0] flt = 5'h00;
	wire logic sclk;
	wire logic cs_n;
	wire logic sdi;
	wire logic sdo;
	logic irq_out_n;
	logic reset_out_n;
	logic transceiver_on;
	logic wake_enable;
	fmirq_mode_e mode;
	logic [7:0] v;
	int errors = 0;
	int num_checks = 0;
	always #2 mclk = ~mclk;
	fmirq_host u_host (.sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo));
	// Short filters keep the run brief; battery keeps its real filter time
	fmirq_core #(.P_UV_CYC(40), .P_OV_CYC(30), .P_SC_CYC(25),
		.P_INITWD_CYC(400), .P_WDUNIT_CYC(20)) u_dut (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.sclk(sclk),
		.spi_cs_n(cs_n),
		.spi_sdi(sdi),
		.spi_sdo(sdo),
		.lin_bus_rx(lin_bus_rx),
		.thermal_shutdown(flt[F_TSD]),
		.core_supply_low(flt[F_UV]),
		.core_supply_high(flt[F_OV]),
		.core_supply_short(flt[F_SC]),
		.battery_supply_low(flt[F_BATT]),
		.irq_out_n(irq_out_n),
		.reset_out_n(reset_out_n),
		.transceiver_on(transceiver_on),
		.wake_enable(wake_enable),
		.mode(mode)
	);
	// ****************************************
	// Helpers
	// ****************************************
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic pin(input logic got, input logic exp);
		chk({7'h00, got}, {7'h00, exp});
	endtask
	// Checks fall on the falling edge, clear of the design's updates
	task automatic cyc_wait(input int n);
		repeat (n) @(negedge mclk);
	endtask
	task automatic wmode(input fmirq_mode_e m, input int n);
		for (int i = 0; i < n && mode !== m; i++) @(negedge mclk);
		chk({2'b00, mode}, {2'b00, m});
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		logic [7:0] r;
		u_host.xfer({1'b1, a, d}, 24, 1'b0, r);
		cyc_wait(8);
	endtask
	// Read data comes back one frame late
	task automatic rdchk(input logic [6:0] a, input logic [7:0] exp);
		logic [7:0] r;
		u_host.xfer({1'b0, a, 8'h00}, 24, 1'b0, r);
		u_host.xfer({1'b0, a, 8'h00}, 24, 1'b0, r);
		chk(r, exp);
	endtask
	task automatic fault(input int i, input int n);
		@(posedge mclk) flt[i] <= 1'b1;
		cyc_wait(n);
	endtask
	task automatic rel;
		@(posedge mclk) flt <= 5'h00;
	endtask
	task automatic clr_all;
		for (int a = 'h50; a <= 'h53; a++) wr(a[6:0], 8'hFF);
		pin(irq_out_n, 1'b1);
	endtask
	task automatic tally_and_finish;
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// ****************************************
	// Tests
	// ****************************************
	initial begin
		cyc_wait(10);
		@(posedge mclk) sys_rst <= 1'b0;
		cyc_wait(2);
		pin(irq_out_n, 1'b1);
		wmode(M_STANDBY, 1);
		pin(reset_out_n, 1'b1);
		pin(wake_enable, 1'b1);
		rdchk(A_ACT, ACT_RST);
		rdchk(A_WDLO, WDLO_RST);
		rdchk(A_WDLIM, WDLIM_RST);
		pin(irq_out_n, 1'b0);
		rdchk(A_WDF, 8'h80);
		clr_all;
		u_host.xfer({1'b1, A_ACT, 8'h1F}, 24, 1'b1, v);
		rdchk(A_LNK, 8'h10);
		rdchk(A_ACT, 8'h00);
		clr_all;
		// Too few and too many clocks
		for (int n = 23; n <= 25; n += 2) begin
			u_host.xfer({1'b1, A_ACT, 8'h1F}, n, 1'b0, v);
			cyc_wait(8);
			pin(irq_out_n, 1'b0);
			rdchk(A_LNK, 8'h80);
			rdchk(A_ACT, 8'h00);
			clr_all;
		end
		wr(A_ACT, 8'h02);
		fault(F_TSD, 2500);
		wmode(M_FAILSAFE, 40);
		cyc_wait(2);
		pin(irq_out_n, 1'b0);
		pin(transceiver_on, 1'b0);
		rel;
		rdchk(A_THERM, 8'hA0);
		rdchk(A_SUP, 8'h02);
		clr_all;
		wr(A_MODE, {6'h00, REQ_STANDBY});
		wmode(M_STANDBY, 4);
		fault(F_SC, 25);
		wmode(M_FAILSAFE, 20);
		rel;
		rdchk(A_LNK, 8'h08);
		// Battery filter runs at its full length
		fault(F_BATT, cyc(T_BATT_NS) + 8);
		rel;
		wmode(M_FAILSAFE, 1);
		rdchk(A_SUP, 8'h10);
		fault(F_UV, 40);
		wmode(M_RESTART, 20);
		cyc_wait(2);
		pin(reset_out_n, 1'b0);
		rdchk(A_SUP, 8'h14);
		rel;
		wmode(M_STANDBY, 20);
		cyc_wait(2);
		pin(reset_out_n, 1'b1);
		// Let the standby window lapse before clearing
		cyc_wait(450);
		clr_all;
		fault(F_OV, 30);
		wmode(M_SLEEP, 20);
		rel;
		@(posedge mclk) lin_bus_rx <= 1'b0;
		cyc_wait(770);
		pin(wake_enable, 1'b0);
		@(posedge mclk) lin_bus_rx <= 1'b1;
		cyc_wait(770);
		pin(wake_enable, 1'b1);
		rdchk(A_SUP, 8'h20);
		wr(A_ACT, 8'h0A);
		wr(A_WDLO, 8'h3F);
		wr(A_WDLIM, 8'h01);
		clr_all;
		@(posedge mclk) lin_bus_rx <= 1'b0;
		wmode(M_STANDBY, 800);
		@(posedge mclk) lin_bus_rx <= 1'b1;
		wr(A_MODE, {6'h00, REQ_NORMAL});
		wmode(M_NORMAL, 4);
		pin(transceiver_on, 1'b1);
		// Never serviced: one error per 1280 cycles
		cyc_wait(1400);
		rdchk(A_WDERR, 8'h01);
		wmode(M_FAILSAFE, 1500);
		cyc_wait(2);
		pin(irq_out_n, 1'b0);
		rdchk(A_WDF, 8'h80);
		rdchk(A_STAT, 8'h08);
		// Thermal event with the protected mode chosen
		wr(A_ACT, 8'h10);
		fault(F_TSD, 2500);
		wmode(M_THERMAL, 40);
		rel;
		wmode(M_STANDBY, 20);
		tally_and_finish;
	end
	initial begin
		cyc_wait(80000);
		errors++;
		tally_and_finish;
	end
endmodule // fmirq_core_tb
`default_nettype wire
